// ===== hw/cba_pkg.sv
// constants and carrier types for the coprocessor bus arbiter
`default_nettype none
package cba_pkg;
	localparam int CBA_SLOTS = 5;
	localparam int CBA_SEL_W = 3;
	// selection codes: coprocessor, slot index 0..n-1, idle
	localparam logic [CBA_SEL_W-1:0] CBA_SEL_COPRO = 3'h7;
	localparam logic [CBA_SEL_W-1:0] CBA_SEL_NONE = 3'h6;
	localparam int CBA_HOLDOFF_TICKS = 1;
	typedef enum logic [1:0] {
		CBA_IDLE = 2'b00,
		CBA_OWNED = 2'b01,
		CBA_GAP = 2'b10
	} cba_state_type;
	// active-low copy of the host side handshake pins
	typedef struct packed {
		logic bus_grant_n;
		logic grant_ack_n;
		logic transfer_ack_n;
		logic addr_strobe_n;
	} cba_host_type;
endpackage
`default_nettype wire

// ===== hw/cba_arbiter.sv
// coprocessor and expansion slot bus arbiter
`default_nettype none
module cba_arbiter #(
	parameter int SLOTS = cba_pkg::CBA_SLOTS
) (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire cba_pkg::cba_host_type host_in,
	input wire logic [SLOTS-1:0] slot_request_n_in,
	input wire logic master_takeover_n_in,
	input wire logic copro_request_n_in,
	input wire logic copro_grant_n_in,
	output logic bus_request_n_out,
	output logic [SLOTS-1:0] slot_grant_n_out,
	output logic copro_grant_n_out,
	output logic copro_grant_oe_out,
	output logic copro_request_n_out,
	output logic copro_request_oe_out
);
	import cba_pkg::*;

	// ------------------------------------------------------------
	// input synchronisers
	// ------------------------------------------------------------
	// every pin except sys_rst_in is asynchronous to this clock, so two flops first
	localparam int NIN = SLOTS + 7;
	logic [NIN-1:0] meta_reg;
	logic [NIN-1:0] sync_reg;
	always_ff @(posedge clk_in) begin
		meta_reg <= {host_in, slot_request_n_in, master_takeover_n_in,
			copro_request_n_in, copro_grant_n_in};
		sync_reg <= meta_reg;
	end

	logic bg_s, ack_s, transfer_ack_s, as_s, master_takeover_s, creq_s, cgnt_s;
	logic [SLOTS-1:0] sreq_s;
	assign bg_s = ~sync_reg[NIN-1];
	assign ack_s = ~sync_reg[NIN-2];
	assign transfer_ack_s = ~sync_reg[NIN-3];
	assign as_s = ~sync_reg[NIN-4];
	assign sreq_s = ~sync_reg[SLOTS+2:3];
	assign master_takeover_s = ~sync_reg[2];
	assign creq_s = ~sync_reg[1];
	assign cgnt_s = ~sync_reg[0];

	// ------------------------------------------------------------
	// priority encoder
	// ------------------------------------------------------------
	// lowest slot index wins
	function automatic logic [CBA_SEL_W-1:0] pick(input logic c, input logic [SLOTS-1:0] r);
		logic [CBA_SEL_W-1:0] s;
		s = CBA_SEL_NONE;
		for (int i = SLOTS - 1; i >= 0; i--) begin
			if (r[i]) begin
				s = CBA_SEL_W'(i);
			end
		end
		if (c) begin
			s = CBA_SEL_COPRO;
		end
		return s;
	endfunction

	// ------------------------------------------------------------
	// arbitration state
	// ------------------------------------------------------------
	cba_state_type state_reg;
	logic [CBA_SEL_W-1:0] sel_reg;
	logic master_takeover_mode;
	logic [CBA_SEL_W-1:0] sel_now;
	logic held;
	assign master_takeover_mode = master_takeover_s;
	// coprocessor latched with slots, never during takeover
	assign sel_now = pick(creq_s & ~master_takeover_mode, sreq_s);
	assign held = (sel_reg == CBA_SEL_COPRO) ? creq_s : sreq_s[sel_reg];

	// gap state holds with grant negated until the host grant drops or takeover is seen
	// latched winner holds until its request and ack drop, or until takeover is seen while the coprocessor holds the latch
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			state_reg <= CBA_IDLE;
			sel_reg <= CBA_SEL_NONE;
		end else begin
			unique case (state_reg)
				CBA_IDLE: begin
					if (sel_now != CBA_SEL_NONE) begin
						state_reg <= CBA_OWNED;
						sel_reg <= sel_now;
					end
				end
				CBA_OWNED: begin
					// takeover frees the latch for slot dma
					// otherwise the coprocessor win would block every slot request
					if ((sel_reg == CBA_SEL_COPRO && master_takeover_s) || (!held && !ack_s)) begin
						state_reg <= CBA_GAP;
						sel_reg <= CBA_SEL_NONE;
					end
				end
				CBA_GAP: begin
					if (!bg_s || master_takeover_mode) begin
						state_reg <= CBA_IDLE;
					end
				end
				default: begin
					state_reg <= CBA_IDLE;
					sel_reg <= CBA_SEL_NONE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// output drivers
	// ------------------------------------------------------------
	logic owned;
	logic grant_src;
	assign owned = (state_reg == CBA_OWNED);
	// takeover grant source is the coprocessor, else host
	assign grant_src = master_takeover_mode ? cgnt_s : bg_s;

	// takeover treated as ownership, host kept off
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			bus_request_n_out <= 1'b1;
		end else begin
			bus_request_n_out <= ~(master_takeover_mode | (owned & ~master_takeover_mode));
		end
	end

	// slot grants never echo onto the coprocessor grant
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			slot_grant_n_out <= '1;
		end else begin
			for (int i = 0; i < SLOTS; i++) begin
				slot_grant_n_out[i] <= ~(owned & grant_src & (sel_reg == CBA_SEL_W'(i)));
			end
		end
	end

	// takeover turns the coprocessor request into an output
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			copro_grant_n_out <= 1'b1;
			copro_grant_oe_out <= 1'b1;
			copro_request_n_out <= 1'b1;
			copro_request_oe_out <= 1'b0;
		end else begin
			copro_grant_n_out <= ~(~master_takeover_mode & owned & bg_s & (sel_reg == CBA_SEL_COPRO));
			copro_grant_oe_out <= ~master_takeover_mode;
			copro_request_n_out <= ~(master_takeover_mode & owned & (sel_reg != CBA_SEL_COPRO));
			copro_request_oe_out <= master_takeover_mode;
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	property p_one_grant;
		@(posedge clk_in) disable iff (sys_rst_in)
		$countones(~{slot_grant_n_out, copro_grant_n_out}) <= 1;
	endproperty
	a_one_grant: assert property (p_one_grant) else $error("two grants at once");

	property p_copro_lock;
		@(posedge clk_in) disable iff (sys_rst_in)
		!copro_grant_n_out |-> &slot_grant_n_out;
	endproperty
	a_copro_lock: assert property (p_copro_lock) else $error("slot grant with copro grant");

	property p_takeover_br;
		@(posedge clk_in) disable iff (sys_rst_in)
		master_takeover_s |=> !bus_request_n_out;
	endproperty
	a_takeover_br: assert property (p_takeover_br) else $error("host request not held");

	property p_takeover_dir;
		@(posedge clk_in) disable iff (sys_rst_in)
		master_takeover_s |=> copro_request_oe_out && !copro_grant_oe_out;
	endproperty
	a_takeover_dir: assert property (p_takeover_dir) else $error("direction not turned");

	property p_copro_won;
		@(posedge clk_in) disable iff (sys_rst_in)
		!copro_grant_n_out |-> $past(sel_reg == CBA_SEL_COPRO);
	endproperty
	a_copro_won: assert property (p_copro_won) else $error("copro grant without win");

	property p_copro_priority;
		@(posedge clk_in) disable iff (sys_rst_in)
		state_reg == CBA_IDLE && creq_s && !master_takeover_s |=> sel_reg == CBA_SEL_COPRO;
	endproperty
	a_copro_priority: assert property (p_copro_priority) else $error("copro lost");

	property p_gap;
		@(posedge clk_in) disable iff (sys_rst_in)
		state_reg == CBA_GAP && bg_s && !master_takeover_s |=> state_reg != CBA_OWNED;
	endproperty
	a_gap: assert property (p_gap) else $error("regrant before grant gap");

	property p_route;
		@(posedge clk_in) disable iff (sys_rst_in)
		owned && !master_takeover_s && bg_s && sel_reg == CBA_SEL_COPRO |=> !copro_grant_n_out;
	endproperty
	a_route: assert property (p_route) else $error("grant not routed");

	property p_pass;
		@(posedge clk_in) disable iff (sys_rst_in)
		owned && master_takeover_s && cgnt_s && sel_reg < CBA_SEL_W'(SLOTS)
		|=> !slot_grant_n_out[$past(sel_reg)];
	endproperty
	a_pass: assert property (p_pass) else $error("takeover grant not passed");

	c_copro: cover property (@(posedge clk_in) !copro_grant_n_out);
	c_slot: cover property (@(posedge clk_in) !slot_grant_n_out[0]);
	c_master_takeover_slot: cover property (@(posedge clk_in) master_takeover_s && !slot_grant_n_out[1]);
endmodule
`default_nettype wire

// ===== dv/cba_host_model.sv
// host processor model answering bus requests
`default_nettype none
module cba_host_model #(
	parameter int DLY = 2
) (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic bus_request_n_in,
	input wire logic grant_ack_n_in,
	input wire logic takeover_n_in,
	output var cba_pkg::cba_host_type host_out
);
	timeunit 1ns;
	timeprecision 100ps;
	import cba_pkg::*;
	// ----
	// grant handshake
	// ----
	int cnt_reg;
	logic bg_reg;
	assign host_out = '{bg_reg, grant_ack_n_in, ~bg_reg, ~bg_reg};
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			cnt_reg <= 0;
			bg_reg <= 1'b1;
		end else if (!bus_request_n_in && bg_reg) begin
			cnt_reg <= cnt_reg + 1;
			bg_reg <= (cnt_reg < DLY);
		end else if (bus_request_n_in && grant_ack_n_in && takeover_n_in) begin
			cnt_reg <= 0;
			bg_reg <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// ===== dv/cba_arbiter_tb.sv
// self-checking bench for the bus arbiter
`default_nettype none
module cba_arbiter_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import cba_pkg::*;
	// ----
	// stimulus and checks
	// ----
	logic clk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic [4:0] sq_n = 5'h1F;
	logic tko_n = 1'b1;
	logic creq_n = 1'b1;
	logic cgnt_n = 1'b1;
	logic ack_n = 1'b1;
	logic br_n, cg_n, cg_oe, cr_n, cr_oe, seen;
	logic [4:0] sg_n;
	cba_host_type host;
	int err_total = 0;
	int check_count = 0;
	int i;
	logic [5:0] rq [5] = '{6'h3E, 6'h35, 6'h2F, 6'h1E, 6'h00};
	logic [5:0] gx [5] = '{6'h3E, 6'h3D, 6'h2F, 6'h1F, 6'h1F};
	wire logic [5:0] gnt = {cg_n, sg_n};
	always #12.5 clk_in = ~clk_in;
	cba_arbiter dut_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .host_in(host),
		.slot_request_n_in(sq_n), .master_takeover_n_in(tko_n),
		.copro_request_n_in(creq_n), .copro_grant_n_in(cgnt_n),
		.bus_request_n_out(br_n), .slot_grant_n_out(sg_n), .copro_grant_n_out(cg_n),
		.copro_grant_oe_out(cg_oe), .copro_request_n_out(cr_n),
		.copro_request_oe_out(cr_oe));
	cba_host_model #(.DLY(3)) host_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
		.bus_request_n_in(br_n), .grant_ack_n_in(ack_n), .takeover_n_in(tko_n),
		.host_out(host));
	task automatic chk(input logic [9:0] got, input logic [9:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_in);
	endtask
	task automatic finish_test;
		$display("errors %0d checks %0d", err_total, check_count);
		if (err_total == 0 && check_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// bounded so a dead grant path cannot hang the run
	task automatic dma(input logic [5:0] r, input logic [5:0] g);
		creq_n <= r[5];
		sq_n <= r[4:0];
		for (i = 0; i < 40 && gnt === 6'h3F; i++) @(negedge clk_in);
		chk(10'(gnt), 10'(g));
		tick(1);
		ack_n <= 1'b0;
		tick(4);
		@(negedge clk_in);
		chk(10'({gnt, cg_oe, cr_oe}), 10'({g, 2'h2}));
		tick(1);
		creq_n <= 1'b1;
		sq_n <= 5'h1F;
		ack_n <= 1'b1;
		tick(16);
	endtask
	initial begin
		tick(16);
		@(negedge clk_in);
		chk({br_n, sg_n, cg_n, cr_n, cg_oe, cr_oe}, 10'h3FE);
		tick(1);
		sys_rst_in <= 1'b0;
		tick(3);
		for (int k = 0; k < 5; k++) dma(rq[k], gx[k]);
		sq_n <= 5'h1E;
		for (i = 0; i < 40 && sg_n === 5'h1F; i++) @(negedge clk_in);
		tick(1);
		ack_n <= 1'b0;
		sq_n <= 5'h1C;
		tick(8);
		@(negedge clk_in);
		chk(10'(gnt), 10'h3E);
		tick(1);
		sq_n <= 5'h1D;
		ack_n <= 1'b1;
		seen = 1'b0;
		for (i = 0; i < 60 && sg_n !== 5'h1D; i++) begin
			@(negedge clk_in);
			if (host.bus_grant_n === 1'b1) seen = 1'b1;
		end
		chk(10'({seen, sg_n}), 10'h3D);
		tick(1);
		sq_n <= 5'h1F;
		tick(16);
		creq_n <= 1'b0;
		for (i = 0; i < 40 && cg_n !== 1'b0; i++) @(negedge clk_in);
		tick(1);
		tko_n <= 1'b0;
		creq_n <= 1'b1;
		tick(6);
		@(negedge clk_in);
		chk(10'({br_n, cr_oe, cg_oe}), 10'h2);
		tick(1);
		sq_n <= 5'h1B;
		for (i = 0; i < 40 && cr_n !== 1'b0; i++) @(negedge clk_in);
		chk(10'(cr_n), 10'h0);
		tick(1);
		cgnt_n <= 1'b0;
		for (i = 0; i < 40 && sg_n === 5'h1F; i++) @(negedge clk_in);
		chk(10'(sg_n), 10'h1B);
		tick(1);
		ack_n <= 1'b0;
		tick(3);
		sq_n <= 5'h1F;
		ack_n <= 1'b1;
		cgnt_n <= 1'b1;
		tick(12);
		@(negedge clk_in);
		chk(10'(sg_n), 10'h1F);
		tick(1);
		tko_n <= 1'b1;
		tick(16);
		@(negedge clk_in);
		chk(10'({br_n, cr_oe, cg_oe}), 10'h5);
		finish_test();
	end
	initial begin
		tick(5000);
		err_total++;
		finish_test();
	end
endmodule
`default_nettype wire
